/* logic/rmac_unit.sv */
// Purpose: register-mapped signed multiplier and multiply-accumulate unit
// Assumes: processor bus strobes are synchronous to clk, one access per cycle
// Notes: accumulator upper half settles one clock after the lower half
`default_nettype none

// Operation
// - operands, product and accumulator are all signed two's complement
// - product and low accumulator bytes readable the cycle after an operand write
// - upper accumulator bytes may settle one cycle later than the lower bytes
// - writing either multiply-only operand updates the product from current X and Y
// - writing either accumulate operand adds current X times Y into the accumulator
// - both X write addresses load one shared X operand
// - both Y write addresses load one shared Y operand
// - writing either clear address zeroes the whole accumulator, data ignored
// - 8-bit operands, 16-bit product, 32-bit accumulator
// - multiply-only results readable immediately with no sequencing limits
// - multiply-only operand registers are write-only, X and Y
// - product high returns bits 15..8, product low bits 7..0
// - accumulate X address reads accumulator bits 15..8, writes X and accumulates
// - accumulate Y address reads accumulator bits 7..0, writes Y and accumulates
// - clear addresses read bits 31..24 and 23..16, writes clear accumulator
// - reached only by register reads and writes on the processor data bus
module rmac_unit (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata
);

  logic [7:0] x_ff;
  logic [7:0] y_ff;
  logic [15:0] prod_ff;
  logic [15:0] acc_lo_ff;
  logic [15:0] acc_hi_ff;
  logic [15:0] hi_addend_ff;
  logic hi_carry_ff;
  logic pending_ff;

  logic wr_x_mul;
  logic wr_y_mul;
  logic wr_x_acc;
  logic wr_y_acc;
  logic wr_clr;
  logic mul_wr;
  logic mac_wr;
  logic [7:0] nxt_x;
  logic [7:0] nxt_y;
  logic [15:0] new_prod;
  logic [15:0] nxt_acc_lo;
  logic lo_carry;
  logic [15:0] nxt_acc_hi;
  logic [31:0] acc_full;
  logic [7:0] nxt_rdata;

  // write decode, the only way in besides reads
  always_comb begin
    wr_x_mul = bus_wr && (bus_addr == rmac_pkg::OFS_X_MUL);
    wr_y_mul = bus_wr && (bus_addr == rmac_pkg::OFS_Y_MUL);
    wr_x_acc = bus_wr && (bus_addr == rmac_pkg::OFS_ACC1_X_ACC);
    wr_y_acc = bus_wr && (bus_addr == rmac_pkg::OFS_ACC0_Y_ACC);
    wr_clr = bus_wr && ((bus_addr == rmac_pkg::OFS_ACC3_CLR_A) ||
                        (bus_addr == rmac_pkg::OFS_ACC2_CLR_B));
    mul_wr = wr_x_mul || wr_y_mul;
    mac_wr = wr_x_acc || wr_y_acc;
  end

  // operand seen by this write: the byte on the bus replaces its side
  always_comb begin
    nxt_x = (wr_x_mul || wr_x_acc) ? bus_wdata : x_ff;
    nxt_y = (wr_y_mul || wr_y_acc) ? bus_wdata : y_ff;
  end

  rmac_smul8 u_mul (
    .op_a(nxt_x),
    .op_b(nxt_y),
    .prod(new_prod)
  );

  // low half adds now, its carry goes to the upper half next clock
  rmac_add16 u_add_lo (
    .add_a(acc_lo_ff),
    .add_b(new_prod),
    .carry_in(1'b0),
    .sum(nxt_acc_lo),
    .carry_out(lo_carry)
  );

  rmac_add16 u_add_hi (
    .add_a(acc_hi_ff),
    .add_b(hi_addend_ff),
    .carry_in(hi_carry_ff),
    .sum(nxt_acc_hi),
    .carry_out()
  );

  always_comb begin
    acc_full = {acc_hi_ff, acc_lo_ff};
  end

  // shared operand registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      x_ff <= rmac_pkg::RST_OPERAND;
      y_ff <= rmac_pkg::RST_OPERAND;
    end else begin
      x_ff <= nxt_x;
      y_ff <= nxt_y;
    end
  end

  // product register, multiply-only path
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prod_ff <= rmac_pkg::RST_PROD;
    end else if (mul_wr) begin
      prod_ff <= new_prod;
    end
  end

  // accumulator lower half, ready the cycle after the write
  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_lo_ff <= rmac_pkg::RST_ACC_HALF;
    end else if (wr_clr) begin
      acc_lo_ff <= rmac_pkg::RST_ACC_HALF;
    end else if (mac_wr) begin
      acc_lo_ff <= nxt_acc_lo;
    end
  end

  // upper half: sign extension of the product plus the low carry
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hi_addend_ff <= rmac_pkg::RST_ACC_HALF;
      hi_carry_ff <= 1'b0;
      pending_ff <= 1'b0;
    end else if (wr_clr) begin
      hi_addend_ff <= rmac_pkg::RST_ACC_HALF;
      hi_carry_ff <= 1'b0;
      pending_ff <= 1'b0;
    end else if (mac_wr) begin
      hi_addend_ff <= {16{new_prod[15]}};
      hi_carry_ff <= lo_carry;
      pending_ff <= 1'b1;
    end else begin
      pending_ff <= 1'b0;
    end
  end

  // completing a pending add while a new one is latched keeps the sum exact
  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_hi_ff <= rmac_pkg::RST_ACC_HALF;
    end else if (wr_clr) begin
      acc_hi_ff <= rmac_pkg::RST_ACC_HALF;
    end else if (pending_ff) begin
      acc_hi_ff <= nxt_acc_hi;
    end
  end

  // read decode, write-only and unmapped addresses read as zero
  always_comb begin
    if (bus_addr == rmac_pkg::OFS_PROD_HI) begin
      nxt_rdata = prod_ff[15:8];
    end else if (bus_addr == rmac_pkg::OFS_PROD_LO) begin
      nxt_rdata = prod_ff[7:0];
    end else if (bus_addr == rmac_pkg::OFS_ACC1_X_ACC) begin
      nxt_rdata = acc_full[15:8];
    end else if (bus_addr == rmac_pkg::OFS_ACC0_Y_ACC) begin
      nxt_rdata = acc_full[7:0];
    end else if (bus_addr == rmac_pkg::OFS_ACC3_CLR_A) begin
      nxt_rdata = acc_full[31:24];
    end else if (bus_addr == rmac_pkg::OFS_ACC2_CLR_B) begin
      nxt_rdata = acc_full[23:16];
    end else begin
      nxt_rdata = rmac_pkg::RD_UNMAPPED;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_rdata <= rmac_pkg::RD_UNMAPPED;
    end else if (bus_rd) begin
      bus_rdata <= nxt_rdata;
    end
  end

  property p_x_shared;
    @(posedge clk) disable iff (!resetn)
    (wr_x_mul || wr_x_acc) |=> (x_ff == $past(bus_wdata));
  endproperty
  a_x_shared: assert property (p_x_shared) else $error("x operand not loaded");

  property p_y_shared;
    @(posedge clk) disable iff (!resetn)
    (wr_y_mul || wr_y_acc) |=> (y_ff == $past(bus_wdata));
  endproperty
  a_y_shared: assert property (p_y_shared) else $error("y operand not loaded");

  property p_mul_prod;
    @(posedge clk) disable iff (!resetn)
    mul_wr |=> (prod_ff == 16'($signed(x_ff) * $signed(y_ff)));
  endproperty
  a_mul_prod: assert property (p_mul_prod) else $error("product wrong after write");

  property p_clear;
    @(posedge clk) disable iff (!resetn)
    wr_clr |=> (acc_full == 32'h00000000) && !pending_ff;
  endproperty
  a_clear: assert property (p_clear) else $error("accumulator not cleared");

  property p_acc_lo;
    @(posedge clk) disable iff (!resetn)
    mac_wr |=> (acc_lo_ff == 16'($past(acc_lo_ff) + $past(new_prod)));
  endproperty
  a_acc_lo: assert property (p_acc_lo) else $error("low accumulator late or wrong");

  property p_acc_full;
    @(posedge clk) disable iff (!resetn)
    (mac_wr && !pending_ff) ##1 !bus_wr |=>
      (acc_full == 32'($past(acc_full, 2) + {{16{$past(new_prod[15], 2)}}, $past(new_prod, 2)}));
  endproperty
  a_acc_full: assert property (p_acc_full) else $error("full accumulate wrong");

  property p_pending;
    @(posedge clk) disable iff (!resetn)
    mac_wr |=> pending_ff ##1 (!pending_ff || $past(mac_wr));
  endproperty
  a_pending: assert property (p_pending) else $error("upper half not one cycle late");

  property p_rd_prod;
    @(posedge clk) disable iff (!resetn)
    (bus_rd && bus_addr == rmac_pkg::OFS_PROD_HI) |=> (bus_rdata == $past(prod_ff[15:8]));
  endproperty
  a_rd_prod: assert property (p_rd_prod) else $error("product high read wrong");

  property p_rd_acc0;
    @(posedge clk) disable iff (!resetn)
    (bus_rd && bus_addr == rmac_pkg::OFS_ACC0_Y_ACC) |=> (bus_rdata == $past(acc_lo_ff[7:0]));
  endproperty
  a_rd_acc0: assert property (p_rd_acc0) else $error("accumulator byte 0 read wrong");

  property p_rd_acc3;
    @(posedge clk) disable iff (!resetn)
    (bus_rd && bus_addr == rmac_pkg::OFS_ACC3_CLR_A) |=> (bus_rdata == $past(acc_hi_ff[15:8]));
  endproperty
  a_rd_acc3: assert property (p_rd_acc3) else $error("accumulator byte 3 read wrong");

  property p_wo;
    @(posedge clk) disable iff (!resetn)
    (bus_rd && (bus_addr == rmac_pkg::OFS_X_MUL || bus_addr == rmac_pkg::OFS_Y_MUL))
      |=> (bus_rdata == 8'h00);
  endproperty
  a_wo: assert property (p_wo) else $error("write-only register read nonzero");

endmodule // rmac_unit

`default_nettype wire

/* logic/rmac_pkg.sv */
// Purpose: constants shared by the register-mapped multiply-accumulate unit
// Assumes: 8-bit processor data bus with 8-bit register addresses
// Notes: offsets are the byte addresses seen by the processor
`default_nettype none

package rmac_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned PROD_W = 16;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned ACC_W = 32;

  localparam logic [7:0] OFS_X_MUL = 8'he8;
  localparam logic [7:0] OFS_Y_MUL = 8'he9;
  localparam logic [7:0] OFS_PROD_HI = 8'hea;
  localparam logic [7:0] OFS_PROD_LO = 8'heb;
  localparam logic [7:0] OFS_ACC1_X_ACC = 8'hec;
  localparam logic [7:0] OFS_ACC0_Y_ACC = 8'hed;
  localparam logic [7:0] OFS_ACC3_CLR_A = 8'hee;
  localparam logic [7:0] OFS_ACC2_CLR_B = 8'hef;

  localparam logic [7:0] RST_OPERAND = 8'h00;
  localparam logic [15:0] RST_PROD = 16'h0000;
  localparam logic [15:0] RST_ACC_HALF = 16'h0000;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

endpackage : rmac_pkg

`default_nettype wire

/* logic/rmac_smul8.sv */
// Purpose: signed 8 x 8 multiplier, two's complement
// Assumes: purely combinational, result used within one clock
// Notes: full 16-bit product, no truncation possible
`default_nettype none

module rmac_smul8 (
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  output logic [15:0] prod
);

  always_comb begin
    prod = $signed(op_a) * $signed(op_b);
  end

endmodule // rmac_smul8

`default_nettype wire

/* logic/rmac_add16.sv */
// Purpose: 16-bit adder slice with carry in and carry out
// Assumes: combinational
// Notes: two slices make the 32-bit accumulator, one per half
`default_nettype none

module rmac_add16 (
  input wire logic [15:0] add_a,
  input wire logic [15:0] add_b,
  input wire logic carry_in,
  output logic [15:0] sum,
  output logic carry_out
);

  always_comb begin
    {carry_out, sum} = {1'b0, add_a} + {1'b0, add_b} + {16'h0000, carry_in};
  end

endmodule // rmac_add16

`default_nettype wire

/* dv/rmac_cpu_model.sv */
// Purpose: processor-side bus master model for the multiply-accumulate unit
// Assumes: one access per cycle, signals change only just after a rising edge
// Notes: released address and data lines invert once per idle call, and hold through the drain wait cycles
`default_nettype none

module rmac_cpu_model (
  input wire logic clk,
  output logic [7:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [7:0] bus_wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    bus_addr = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
  end

  // one access, held across exactly one sampling edge
  task automatic xfer(input logic wr, input logic rd, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge clk);
    bus_wr <= wr;
    bus_rd <= rd;
    bus_addr <= a;
    bus_wdata <= d;
  endtask

  task automatic idle();
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    bus_addr <= ~bus_addr;
    bus_wdata <= ~bus_wdata;
  endtask
endmodule // rmac_cpu_model

`default_nettype wire

/* dv/tb_register_mapped_multiply_accumulate.sv */
// Purpose: self-checking bench for the register-mapped multiply-accumulate unit
// Assumes: read data appears one cycle after the read edge
// Notes: driver queues expected bytes, monitor pops one per completed read
`default_nettype none

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tb_register_mapped_multiply_accumulate;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] bus_addr;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  int n_fail = 0;
  int compares = 0;
  logic [7:0] exp_q[$];
  logic [7:0] e_v;
  logic pend = 1'b0;
  logic [7:0] x_m, y_m;
  logic [15:0] prod_m;
  logic [31:0] acc_m;
  logic [7:0] bnd [5] = '{8'h80, 8'h7f, 8'hff, 8'h80, 8'h01};

  always #10 clk = ~clk;

  rmac_cpu_model cpu (.clk(clk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata));
  rmac_unit uut (.clk(clk), .resetn(resetn), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

  // sign-extend both bytes, keep the low 16 bits of the product
  function automatic logic [15:0] smul(input logic [7:0] a, input logic [7:0] b);
    return {{8{a[7]}}, a} * {{8{b[7]}}, b};
  endfunction

  // both bytes sign-extended to 32 bits, so the product lands sign-extended
  function automatic logic [31:0] smul32(input logic [7:0] a, input logic [7:0] b);
    return {{24{a[7]}}, a} * {{24{b[7]}}, b};
  endfunction

  task automatic model_zero();
    x_m = 8'h00;
    y_m = 8'h00;
    prod_m = 16'h0000;
    acc_m = 32'h0000_0000;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    case (a)
      rmac_pkg::OFS_X_MUL: begin x_m = d; prod_m = smul(x_m, y_m); end
      rmac_pkg::OFS_Y_MUL: begin y_m = d; prod_m = smul(x_m, y_m); end
      rmac_pkg::OFS_ACC1_X_ACC: begin x_m = d; acc_m += smul32(x_m, y_m); end
      rmac_pkg::OFS_ACC0_Y_ACC: begin y_m = d; acc_m += smul32(x_m, y_m); end
      rmac_pkg::OFS_ACC3_CLR_A, rmac_pkg::OFS_ACC2_CLR_B: acc_m = 32'h0000_0000;
      default: ;
    endcase
    cpu.xfer(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    case (a)
      rmac_pkg::OFS_PROD_HI: exp_q.push_back(prod_m[15:8]);
      rmac_pkg::OFS_PROD_LO: exp_q.push_back(prod_m[7:0]);
      rmac_pkg::OFS_ACC1_X_ACC: exp_q.push_back(acc_m[15:8]);
      rmac_pkg::OFS_ACC0_Y_ACC: exp_q.push_back(acc_m[7:0]);
      rmac_pkg::OFS_ACC3_CLR_A: exp_q.push_back(acc_m[31:24]);
      rmac_pkg::OFS_ACC2_CLR_B: exp_q.push_back(acc_m[23:16]);
      default: exp_q.push_back(rmac_pkg::RD_UNMAPPED);
    endcase
    cpu.xfer(1'b0, 1'b1, a, 8'($urandom));
  endtask

  task automatic rd_all();
    int k;
    for (k = 0; k < 10; k++) rd(8'he6 + 8'(k));
  endtask

  task automatic drain();
    int k;
    cpu.idle();
    for (k = 0; k < 8 && exp_q.size() != 0; k++) @(posedge clk);
    if (exp_q.size() != 0) begin
      n_fail++;
      end_sim();
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    if (pend) begin
      e_v = exp_q.pop_front();
      `CHK("bus_rdata", e_v, bus_rdata)
    end
    pend <= bus_rd && resetn;
  end

  initial begin
    int i;
    logic [7:0] a;
    void'($urandom(32'hc44dc190));
    model_zero();
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd_all();
    for (i = 0; i < 16; i++) begin
      a = (i < 5) ? bnd[i] : 8'($urandom);
      wr(rmac_pkg::OFS_X_MUL, a);
      wr(rmac_pkg::OFS_Y_MUL, (i < 5) ? bnd[4 - i] : 8'($urandom));
      rd(rmac_pkg::OFS_PROD_HI);
      rd(rmac_pkg::OFS_PROD_LO);
    end
    for (i = 0; i < 32; i++) begin
      a = (i < 5) ? bnd[i] : 8'($urandom);
      if (i[0]) begin
        wr(rmac_pkg::OFS_Y_MUL, a);
        wr(rmac_pkg::OFS_ACC1_X_ACC, 8'($urandom));
      end else begin
        wr(rmac_pkg::OFS_X_MUL, a);
        wr(rmac_pkg::OFS_ACC0_Y_ACC, 8'($urandom));
      end
      if (i % 8 == 7) wr(8'hee | 8'(i[3]), 8'($urandom));
      rd(rmac_pkg::OFS_ACC0_Y_ACC);
      rd(rmac_pkg::OFS_ACC1_X_ACC);
      rd(rmac_pkg::OFS_ACC3_CLR_A);
      rd(rmac_pkg::OFS_ACC2_CLR_B);
      rd(rmac_pkg::OFS_PROD_LO);
      cpu.idle();
    end
    wr(rmac_pkg::OFS_X_MUL, 8'h7f);
    wr(rmac_pkg::OFS_ACC0_Y_ACC, 8'h81);
    wr(8'he7, 8'h5a);
    wr(rmac_pkg::OFS_PROD_HI, 8'ha5);
    rd_all();
    drain();
    @(posedge clk) resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    model_zero();
    rd_all();
    wr(rmac_pkg::OFS_X_MUL, 8'h03);
    rd_all();
    drain();
    end_sim();
  end
endmodule // tb_register_mapped_multiply_accumulate

`default_nettype wire
